/* design/ccl_pkg.sv */
package ccl_pkg;
    localparam int CCL_NCH = 4;
    // command byte layout
    localparam int CMD_DIR_BIT = 7;
    localparam logic [6:0] IDX_DEBOUNCE = 7'h02;
    localparam logic [6:0] IDX_PIN_DATA = 7'h03;
    localparam logic [6:0] IDX_TX_SLOT = 7'h04;
    localparam logic [6:0] IDX_RX_SLOT = 7'h05;
    localparam logic [6:0] IDX_MON_LOW = 7'h06;
    localparam logic [6:0] IDX_MON_HIGH = 7'h07;
    localparam logic [6:0] IDX_POWER_GAIN = 7'h08;
    localparam logic [6:0] IDX_TONE = 7'h09;
    // debounce config fields
    localparam int DEB_OFFHOOK_LSB = 0;
    localparam int DEB_GROUNDKEY_LSB = 4;
    localparam logic [7:0] DEB_RST = 8'h00;
    // pin data fields
    localparam int PIN_SI1_BIT = 0;
    localparam int PIN_SI2_BIT = 1;
    localparam int PIN_SB_LSB = 2;
    localparam int PIN_SO1_BIT = 5;
    localparam int PIN_SO2_BIT = 6;
    localparam logic [1:0] PIN_SO_RST = 2'h0;
    // slot select fields
    localparam int SLOT_HWY_BIT = 7;
    localparam logic [7:0] SLOT_RST = 8'h00;
    // power and gain fields
    localparam int PG_PD_BIT = 7;
    localparam int PG_CUT_BIT = 6;
    localparam int PG_GAD_BIT = 5;
    localparam int PG_GDA_BIT = 4;
    localparam logic [3:0] PG_RST = 4'h8;
    // tone enable fields
    localparam int TONE_TONE_GEN_ZERO_ENABLE_BIT = 0;
    localparam int TONE_TONE_GEN_ONE_ENABLE_BIT = 1;
    localparam logic [3:0] TONE_RST = 4'h0;
    localparam logic [7:0] MON_HIGH_COMPANDED = 8'h00;
    localparam logic [7:0] RD_UNMAPPED = 8'h00;
    // debounce timing
    localparam int DEB_STEP_MS = 2;
    localparam int GK_MIN_FACTOR = 6;
    localparam int CLK_PERIOD_PS = 5000;
    localparam int MS_PS = 1000000000;
    localparam int MS_CYCLES = MS_PS / CLK_PERIOD_PS;
endpackage

/* design/ccl_regs.sv */
`timescale 1ns/10ps
module ccl_regs
    import ccl_pkg::*;
#(
    parameter int NCH = CCL_NCH,
    parameter int MS_CYC = MS_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_byte,
    input wire logic [1:0] cmd_chan,
    input wire logic [7:0] cmd_wdata,
    output logic [7:0] rd_data,
    output logic rd_valid,
    input wire logic [NCH-1:0] si1_pin,
    input wire logic [NCH-1:0] si2_pin,
    input wire logic [NCH*3-1:0] sb_in,
    input wire logic [NCH*3-1:0] sb_dir_out,
    input wire logic [NCH*3-1:0] sb_global_val,
    output logic [NCH*3-1:0] sb_out,
    output logic [NCH*3-1:0] sb_oe,
    output logic [NCH-1:0] so1_pin,
    output logic [NCH-1:0] so2_pin,
    output logic [NCH-1:0] si1_debounced,
    output logic [NCH-1:0] si2_debounced,
    input wire logic [NCH*16-1:0] tx_sample,
    input wire logic linear_mode,
    output logic [NCH*7-1:0] tx_slot,
    output logic [NCH-1:0] tx_hwy_two,
    output logic [NCH*7-1:0] rx_slot,
    output logic [NCH-1:0] rx_hwy_two,
    output logic [NCH-1:0] chan_power_down,
    output logic [NCH-1:0] rx_path_cutoff,
    output logic [NCH-1:0] adc_gain_plus6,
    output logic [NCH-1:0] dac_gain_minus6,
    output logic [NCH-1:0] tone_zero_en,
    output logic [NCH-1:0] tone_one_en
);
    localparam int MSW = (MS_CYC > 1) ? $clog2(MS_CYC) : 1;

    // channel select is two bits wide, tick counter needs at least one cycle
    generate
        if (NCH < 1 || NCH > 4) begin : g_bad_nch
            $error("ccl_regs: NCH must be 1 to 4");
        end
        if (MS_CYC < 1) begin : g_bad_ms
            $error("ccl_regs: MS_CYC must be at least 1");
        end
        // debounce counter saturates at FF, longest target must stay below it
        if (15 * DEB_STEP_MS * GK_MIN_FACTOR > 254) begin : g_bad_deb
            $error("ccl_regs: debounce target exceeds counter range");
        end
    endgenerate

    function automatic logic [7:0] deb_target(input logic [3:0] code, input logic gk);
        logic [7:0] t;
        t = 8'(code) * 8'(DEB_STEP_MS);
        if (gk) begin
            t = 8'(t * 8'(GK_MIN_FACTOR));
        end
        return t;
    endfunction

    logic [MSW-1:0] ms_cnt_r;
    logic ms_tick;
    logic cmd_wr;
    logic cmd_rd;
    logic [6:0] cmd_idx;

    logic [7:0] deb_cfg_r [NCH];
    logic [1:0] so_r [NCH];
    logic [7:0] tx_sel_r [NCH];
    logic [7:0] rx_sel_r [NCH];
    logic [3:0] pg_r [NCH];
    logic [3:0] tone_r [NCH];
    logic [7:0] pin_view [NCH];
    logic [7:0] rd_data_nxt;

    // command decode
    assign cmd_wr = cmd_byte[CMD_DIR_BIT];
    assign cmd_idx = cmd_byte[6:0];
    assign cmd_rd = cmd_valid && !cmd_wr;

    // millisecond tick
    assign ms_tick = (ms_cnt_r == MSW'(MS_CYC - 1));
    always_ff @(posedge clk_sys) begin
        if (rst || ms_tick) begin
            ms_cnt_r <= '0;
        end else begin
            ms_cnt_r <= ms_cnt_r + 1'b1;
        end
    end

    genvar c, b;
    generate
        for (c = 0; c < NCH; c++) begin : g_ch
            logic sel;
            logic [1:0] si_s1_r;
            logic [1:0] si_s2_r;
            logic [2:0] sb_s1_r;
            logic [2:0] sb_s2_r;
            logic [1:0] deb_r;
            logic [7:0] deb_cnt_r [2];
            logic [2:0] sb_val;

            assign sel = cmd_valid && cmd_wr && (cmd_chan == 2'(c));

            // debounce config
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    deb_cfg_r[c] <= DEB_RST;
                end else if (sel && cmd_idx == IDX_DEBOUNCE) begin
                    deb_cfg_r[c] <= cmd_wdata;
                end
            end

            // pin data: bidir bits are not stored, outputs come from global regs
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    so_r[c] <= PIN_SO_RST;
                end else if (sel && cmd_idx == IDX_PIN_DATA) begin
                    so_r[c] <= {cmd_wdata[PIN_SO2_BIT], cmd_wdata[PIN_SO1_BIT]};
                end
            end

            // transmit slot and highway
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    tx_sel_r[c] <= SLOT_RST;
                end else if (sel && cmd_idx == IDX_TX_SLOT) begin
                    tx_sel_r[c] <= cmd_wdata;
                end
            end

            // receive slot and highway
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    rx_sel_r[c] <= SLOT_RST;
                end else if (sel && cmd_idx == IDX_RX_SLOT) begin
                    rx_sel_r[c] <= cmd_wdata;
                end
            end

            // power and gain: low nibble expected zero and reads back zero
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    pg_r[c] <= PG_RST;
                end else if (sel && cmd_idx == IDX_POWER_GAIN) begin
                    pg_r[c] <= cmd_wdata[7:4];
                end
            end

            // tone enables: bits 3:2 expected high and read back as written
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    tone_r[c] <= TONE_RST;
                end else if (sel && cmd_idx == IDX_TONE) begin
                    tone_r[c] <= cmd_wdata[3:0];
                end
            end

            // signalling input synchronisers
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    si_s1_r <= 2'h0;
                    si_s2_r <= 2'h0;
                end else begin
                    si_s1_r <= {si2_pin[c], si1_pin[c]};
                    si_s2_r <= si_s1_r;
                end
            end

            // bidir pin input synchronisers
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    sb_s1_r <= 3'h0;
                    sb_s2_r <= 3'h0;
                end else begin
                    sb_s1_r <= sb_in[c*3 +: 3];
                    sb_s2_r <= sb_s1_r;
                end
            end

            // debounce of the two signalling inputs
            for (b = 0; b < 2; b++) begin : g_deb
                logic [7:0] target;
                assign target = deb_target(
                    deb_cfg_r[c][(b == 0 ? DEB_OFFHOOK_LSB : DEB_GROUNDKEY_LSB) +: 4],
                    (b == 1));
                // count must pass the target so the full programmed time elapses
                always_ff @(posedge clk_sys) begin
                    if (rst) begin
                        deb_r[b] <= 1'b0;
                        deb_cnt_r[b] <= 8'h00;
                    end else if (si_s2_r[b] == deb_r[b]) begin
                        deb_cnt_r[b] <= 8'h00;
                    end else if (target == 8'h00 || deb_cnt_r[b] > target) begin
                        deb_r[b] <= si_s2_r[b];
                        deb_cnt_r[b] <= 8'h00;
                    end else if (ms_tick && deb_cnt_r[b] != 8'hFF) begin
                        deb_cnt_r[b] <= deb_cnt_r[b] + 8'h01;
                    end
                end
            end

            // bidir pin drive and readback
            for (b = 0; b < 3; b++) begin : g_sb
                always_ff @(posedge clk_sys) begin
                    if (rst) begin
                        sb_out[c*3+b] <= 1'b0;
                        sb_oe[c*3+b] <= 1'b0;
                    end else begin
                        sb_out[c*3+b] <= sb_global_val[c*3+b];
                        sb_oe[c*3+b] <= sb_dir_out[c*3+b];
                    end
                end
                assign sb_val[b] = sb_dir_out[c*3+b] ? sb_out[c*3+b] : sb_s2_r[b];
            end

            assign pin_view[c] = {1'b0, so_r[c][1], so_r[c][0], sb_val,
                                  deb_r[1], deb_r[0]};

            assign so1_pin[c] = so_r[c][0];
            assign so2_pin[c] = so_r[c][1];
            assign si1_debounced[c] = deb_r[PIN_SI1_BIT];
            assign si2_debounced[c] = deb_r[PIN_SI2_BIT];
            assign tx_slot[c*7 +: 7] = tx_sel_r[c][6:0];
            assign tx_hwy_two[c] = tx_sel_r[c][SLOT_HWY_BIT];
            assign rx_slot[c*7 +: 7] = rx_sel_r[c][6:0];
            assign rx_hwy_two[c] = rx_sel_r[c][SLOT_HWY_BIT];
            assign chan_power_down[c] = pg_r[c][PG_PD_BIT-4];
            assign rx_path_cutoff[c] = pg_r[c][PG_CUT_BIT-4];
            assign adc_gain_plus6[c] = pg_r[c][PG_GAD_BIT-4];
            assign dac_gain_minus6[c] = pg_r[c][PG_GDA_BIT-4];
            assign tone_zero_en[c] = tone_r[c][TONE_TONE_GEN_ZERO_ENABLE_BIT];
            assign tone_one_en[c] = tone_r[c][TONE_TONE_GEN_ONE_ENABLE_BIT];
        end
    endgenerate

    // read mux
    always_comb begin
        int ch;
        logic [15:0] smp;
        ch = 0;
        smp = 16'h0000;
        rd_data_nxt = RD_UNMAPPED;
        // channels beyond NCH read as unmapped
        if (int'(cmd_chan) < NCH) begin
            ch = int'(cmd_chan);
            smp = tx_sample[ch*16 +: 16];
            case (cmd_idx)
                IDX_DEBOUNCE: rd_data_nxt = deb_cfg_r[ch];
                IDX_PIN_DATA: rd_data_nxt = pin_view[ch];
                IDX_TX_SLOT: rd_data_nxt = tx_sel_r[ch];
                IDX_RX_SLOT: rd_data_nxt = rx_sel_r[ch];
                IDX_MON_LOW: rd_data_nxt = smp[7:0];
                IDX_MON_HIGH: rd_data_nxt = linear_mode ? smp[15:8]
                                                        : MON_HIGH_COMPANDED;
                IDX_POWER_GAIN: rd_data_nxt = {pg_r[ch], 4'h0};
                IDX_TONE: rd_data_nxt = {4'h0, tone_r[ch]};
                default: rd_data_nxt = RD_UNMAPPED;
            endcase
        end
    end

    // read strobe, one cycle after the command
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= cmd_rd;
        end
    end

    // read data holds until the next read
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rd_data <= 8'h00;
        end else if (cmd_rd) begin
            rd_data <= rd_data_nxt;
        end
    end
endmodule // ccl_regs

/* bench/ccl_regs_sva.sv */
`timescale 1ns/10ps
module ccl_regs_sva #(parameter int NCH = 4) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_byte,
    input wire logic [1:0] cmd_chan,
    input wire logic [7:0] cmd_wdata,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid,
    input wire logic [NCH*16-1:0] tx_sample,
    input wire logic linear_mode,
    input wire logic [NCH*7-1:0] tx_slot,
    input wire logic [NCH-1:0] tx_hwy_two,
    input wire logic [NCH*7-1:0] rx_slot,
    input wire logic [NCH-1:0] rx_hwy_two,
    input wire logic [NCH-1:0] chan_power_down,
    input wire logic [NCH-1:0] rx_path_cutoff,
    input wire logic [NCH-1:0] tone_zero_en,
    input wire logic [NCH-1:0] tone_one_en,
    input wire logic [NCH-1:0] si1_debounced
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    logic rq;
    logic [7:0] w0;
    assign rq = cmd_valid && !cmd_byte[7];
    assign w0 = (cmd_valid && cmd_chan == 2'h0) ? cmd_byte : 8'h00;
    property p_rdv; rq |=> rd_valid; endproperty
    a_rdv: assert property (p_rdv) else $error("read not answered");
    property p_nordv; !rq |=> !rd_valid; endproperty
    a_nordv: assert property (p_nordv) else $error("stray read answer");
    property p_pd;
        w0 == 8'h88 |=> {chan_power_down[0], rx_path_cutoff[0]} == $past(cmd_wdata[7:6]);
    endproperty
    a_pd: assert property (p_pd) else $error("power bits wrong");
    property p_ten;
        w0 == 8'h89 |=> {tone_one_en[0], tone_zero_en[0]} == $past(cmd_wdata[1:0]);
    endproperty
    a_ten: assert property (p_ten) else $error("tone enables wrong");
    property p_tx; w0 == 8'h84 |=> {tx_hwy_two[0], tx_slot[6:0]} == $past(cmd_wdata); endproperty
    a_tx: assert property (p_tx) else $error("tx slot wrong");
    property p_rx; w0 == 8'h85 |=> {rx_hwy_two[0], rx_slot[6:0]} == $past(cmd_wdata); endproperty
    a_rx: assert property (p_rx) else $error("rx slot wrong");
    property p_mlo;
        rq && cmd_chan == 2'h0 && cmd_byte[6:0] == 7'h06 |=> rd_data == $past(tx_sample[7:0]);
    endproperty
    a_mlo: assert property (p_mlo) else $error("monitor low wrong");
    property p_mhi;
        rq && cmd_chan == 2'h0 && cmd_byte[6:0] == 7'h07
            |=> rd_data == ($past(linear_mode) ? $past(tx_sample[15:8]) : 8'h00);
    endproperty
    a_mhi: assert property (p_mhi) else $error("monitor high wrong");
    c_wr: cover property (w0 == 8'h88);
    c_mon: cover property (rq && cmd_byte[6:0] == 7'h07 && linear_mode);
    c_deb: cover property ($rose(si1_debounced[0]));
endmodule // ccl_regs_sva

/* bench/ccl_host.sv */
`timescale 1ns/10ps
module ccl_host (
    input wire logic clk_sys,
    output logic cmd_valid,
    output logic [7:0] cmd_byte,
    output logic [1:0] cmd_chan,
    output logic [7:0] cmd_wdata
);
    initial begin
        cmd_valid = 1'b0;
        cmd_byte = 8'h00;
        cmd_chan = 2'h0;
        cmd_wdata = 8'h00;
    end
    task automatic xfer(input logic wr, input logic [6:0] i, input logic [1:0] c,
        input logic [7:0] d);
        logic [7:0] v;
        v = d;
        if (wr && i == 7'h08) v[3:0] = 4'h0;
        if (wr && i == 7'h09) v[3:2] = 2'h3;
        @(negedge clk_sys);
        cmd_valid = 1'b1;
        cmd_byte = {wr, i};
        cmd_chan = c;
        cmd_wdata = v;
        @(negedge clk_sys);
        cmd_valid = 1'b0;
        cmd_byte = ~cmd_byte;
        cmd_wdata = ~v;
    endtask
endmodule // ccl_host

/* bench/test_codec_channel_local_registers.sv */
`timescale 1ns/10ps
module test_codec_channel_local_registers;
    localparam int NCH = 4;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic cmd_valid, rd_valid, linear_mode = 1'b1;
    logic [7:0] cmd_byte, cmd_wdata, rd_data;
    logic [1:0] cmd_chan;
    logic [NCH-1:0] si1_pin = '0, si2_pin = '0, so1_pin, so2_pin, si1_debounced, si2_debounced;
    logic [NCH-1:0] tx_hwy_two, rx_hwy_two, chan_power_down, rx_path_cutoff;
    logic [NCH-1:0] adc_gain_plus6, dac_gain_minus6, tone_zero_en, tone_one_en;
    logic [NCH*3-1:0] sb_in = '0, sb_dir_out = '0, sb_global_val = '0, sb_out, sb_oe;
    logic [NCH*16-1:0] tx_sample = '0;
    logic [NCH*7-1:0] tx_slot, rx_slot;
    logic [7:0] expq[$];
    logic [6:0] wi[5] = '{7'h04, 7'h05, 7'h02, 7'h08, 7'h09};
    logic [6:0] ri[6] = '{7'h02, 7'h03, 7'h04, 7'h05, 7'h08, 7'h09};
    logic [7:0] rr[6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00};
    int err_count = 0;
    int checked = 0;
    ccl_regs #(.MS_CYC(10)) u_dut (.*);
    ccl_host u_host (.*);
    always #2.5 clk_sys = ~clk_sys;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp || $isunknown(got)) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [6:0] i, input logic [1:0] c, input logic [7:0] e);
        expq.push_back(e);
        u_host.xfer(1'b0, i, c, 8'h00);
    endtask
    task automatic deb(input bit two, input int lo, input int hi);
        int n;
        n = 0;
        while ((two ? si2_debounced[0] : si1_debounced[0]) !== 1'b1 && n < hi) begin
            @(negedge clk_sys);
            n++;
        end
        chk({7'h00, n >= lo && n < hi}, 8'h01);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    always @(negedge clk_sys) begin
        if (rd_valid === 1'b1) begin
            if (expq.size() > 0) chk(rd_data, expq.pop_front());
            else chk(rd_data, ~rd_data);
        end
    end
    initial begin
        logic [7:0] w[NCH][5];
        void'($urandom(65));
        repeat (6) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'b0;
        foreach (ri[i]) rd(ri[i], 2'h3, rr[i]);
        $display("test reset done");
        for (int c = 0; c < NCH; c++) begin
            for (int k = 0; k < 5; k++) begin
                w[c][k] = 8'($urandom);
                u_host.xfer(1'b1, wi[k], c[1:0], w[c][k]);
            end
        end
        for (int c = 0; c < NCH; c++) begin
            rd(7'h04, c[1:0], w[c][0]);
            rd(7'h05, c[1:0], w[c][1]);
            rd(7'h02, c[1:0], w[c][2]);
            rd(7'h08, c[1:0], {w[c][3][7:4], 4'h0});
            rd(7'h09, c[1:0], {6'h03, w[c][4][1:0]});
            chk({tx_hwy_two[c], tx_slot[c*7+:7]}, w[c][0]);
            chk({rx_hwy_two[c], rx_slot[c*7+:7]}, w[c][1]);
            chk({chan_power_down[c], rx_path_cutoff[c], adc_gain_plus6[c], dac_gain_minus6[c],
                4'h0}, {w[c][3][7:4], 4'h0});
            chk({6'h00, tone_one_en[c], tone_zero_en[c]}, {6'h00, w[c][4][1:0]});
        end
        $display("test regs done");
        tx_sample[15:0] = 16'($urandom);
        u_host.xfer(1'b1, 7'h06, 2'h0, 8'hFF);
        u_host.xfer(1'b1, 7'h07, 2'h0, 8'hFF);
        rd(7'h06, 2'h0, tx_sample[7:0]);
        rd(7'h07, 2'h0, tx_sample[15:8]);
        linear_mode = 1'b0;
        rd(7'h07, 2'h0, 8'h00);
        rd(7'h06, 2'h0, tx_sample[7:0]);
        rd(7'h0A, 2'h0, 8'h00);
        $display("test monitor done");
        sb_dir_out[2:0] = 3'h5;
        sb_global_val[2:0] = 3'h1;
        sb_in[2:0] = 3'h2;
        u_host.xfer(1'b1, 7'h03, 2'h0, 8'h7F);
        rd(7'h03, 2'h0, 8'h6C);
        chk({so2_pin[0], so1_pin[0], sb_oe[2:0], sb_out[2:0]}, 8'hE9);
        $display("test pins done");
        u_host.xfer(1'b1, 7'h02, 2'h0, 8'h21);
        si1_pin[0] = 1'b1;
        si2_pin[0] = 1'b1;
        // 10 cycles per ms: 2 ms and 24 ms plus two synchroniser cycles at least
        fork
            deb(1'b0, 22, 35);
            deb(1'b1, 242, 260);
        join
        rd(7'h03, 2'h0, 8'h6F);
        repeat (4) @(negedge clk_sys);
        chk(8'(expq.size()), 8'h00);
        $display("test debounce done");
        results();
    end
endmodule // test_codec_channel_local_registers
bind ccl_regs ccl_regs_sva #(.NCH(NCH)) u_sva (.*);
